/* rtl/hbmc_defines.vh */
// Purpose: Shared constants of the dual H-bridge motor drive control
// Assumes: 100 MHz clock, one control word and one status word
// Notes:   Times are given in ns and turned into cycle counts here
`ifndef HBMC_DEFINES_VH
`define HBMC_DEFINES_VH

// Register map (byte offsets)
`define HBMC_ADDR_W      4
`define HBMC_OFS_CTRL    4'h0
`define HBMC_OFS_STAT    4'h4

// Control word layout and reset value
`define HBMC_CTRL_W      22
`define HBMC_CTRL_RST    22'h1b006e
`define HBMC_BIT_REG_EN  1
`define HBMC_BIT_DC_DIR2 12
`define HBMC_BIT_DC_DIR1 13
`define HBMC_DRV2_BASE   2
`define HBMC_DRV1_BASE   16
`define HBMC_PH_B_OFS    0
`define HBMC_PH_A_OFS    3
`define HBMC_F_LVL_HI    0
`define HBMC_F_LVL_LO    1
`define HBMC_F_DIR       2

// Leg commands
`define HBMC_LEG_OFF     2'h0
`define HBMC_LEG_HIGH    2'h1
`define HBMC_LEG_LOW     2'h2

// Timing
`define HBMC_CLK_NS      10
`define HBMC_CLK_HZ      100000000
`define HBMC_SW_HZ       200000
`define HBMC_SW_CYC      (`HBMC_CLK_HZ / `HBMC_SW_HZ)
`define HBMC_ON_PERMIL   375
`define HBMC_ON_CYC      (`HBMC_SW_CYC * `HBMC_ON_PERMIL / 1000)
`define HBMC_DEAD_NS     500
`define HBMC_DEAD_CYC    ((`HBMC_DEAD_NS + `HBMC_CLK_NS - 1) / `HBMC_CLK_NS)
`define HBMC_BLANK_NS    1000
`define HBMC_BLANK_CYC   ((`HBMC_BLANK_NS + `HBMC_CLK_NS - 1) / `HBMC_CLK_NS)

`endif

/* rtl/hbmc_leg.v */
// Purpose: One bridge side: upper and lower switch with dead time
// Assumes: Command changes are slow compared with the dead time
// Notes:   Both gates pass through off before any new state
`include "hbmc_defines.vh"

module hbmc_leg (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [1:0] cmd,
  output reg        hi_gate_reg,
  output reg        lo_gate_reg
);

  localparam integer DEAD_I = `HBMC_DEAD_CYC;  // Dead time, full width
  localparam [6:0]   DEAD   = DEAD_I[6:0];     // Cut to counter width

  reg [1:0] state_reg;  // Applied leg state
  reg [6:0] dead_reg;   // Remaining dead time

  // Leave the old state, wait dead time, then take the new one
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= `HBMC_LEG_OFF;
      dead_reg  <= DEAD;
    end else if (cmd != state_reg) begin
      if (state_reg != `HBMC_LEG_OFF) begin
        state_reg <= `HBMC_LEG_OFF;  // R4
        dead_reg  <= DEAD;           // R4
      end else if (dead_reg != 7'h0) begin
        dead_reg <= dead_reg - 7'h1;
      end else begin
        state_reg <= cmd;
      end
    end else if (dead_reg != 7'h0) begin
      dead_reg <= dead_reg - 7'h1;
    end
  end

  // Gates decoded from one state, never both on
  always @(posedge clk) begin
    if (!rst_n) begin
      hi_gate_reg <= 1'b0;
      lo_gate_reg <= 1'b0;
    end else begin
      hi_gate_reg <= (state_reg == `HBMC_LEG_HIGH);  // R4
      lo_gate_reg <= (state_reg == `HBMC_LEG_LOW);   // R4
    end
  end

endmodule // hbmc_leg

/* rtl/hbmc_phase.v */
// Purpose: One H-bridge: step chopping or DC drive, per-side commands
// Assumes: Sense trip is already synchronised
// Notes:   Chop period is one switching period of the internal clock
`include "hbmc_defines.vh"

module hbmc_phase (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       chop_tick,
  input  wire       drive_en,
  input  wire       step_mode,
  input  wire       dir,
  input  wire       lvl_lo,
  input  wire       lvl_hi,
  input  wire       dc_pwm,
  input  wire       overtemp,
  input  wire       sense_trip,
  output reg  [1:0] cmd_a_reg,
  output reg  [1:0] cmd_b_reg,
  output reg  [1:0] level_reg
);

  localparam integer BLANK_I = `HBMC_DEAD_CYC + `HBMC_BLANK_CYC;  // Full width
  localparam [7:0]   BLANK   = BLANK_I[7:0];  // Cut to counter width

  // Current level code: 00 full, 01 two thirds, 10 one third, 11 zero
  function [1:0] lvl_decode;
    input hi;
    input lo;
    begin
      case ({hi, lo})
        2'h0:    lvl_decode = 2'h3;
        2'h1:    lvl_decode = 2'h2;
        2'h2:    lvl_decode = 2'h1;
        default: lvl_decode = 2'h0;
      endcase
    end
  endfunction

  reg       on_reg;      // Chop on-phase
  reg [7:0] blank_reg;   // Sense ignored while nonzero
  reg [1:0] cmd_a_next;
  reg [1:0] cmd_b_next;
  wire      zero_state = lvl_hi & lvl_lo;

  // Turn on each period, turn off on sense trip after blanking
  always @(posedge clk) begin
    if (!rst_n) begin
      on_reg    <= 1'b0;
      blank_reg <= 8'h0;
    end else if (chop_tick) begin
      on_reg    <= 1'b1;
      blank_reg <= BLANK;                    // R5
    end else if (blank_reg != 8'h0) begin
      blank_reg <= blank_reg - 8'h1;         // R5
    end else if (sense_trip) begin
      on_reg <= 1'b0;                        // R3
    end
  end

  // Side commands from mode, fault and direction
  always @* begin
    cmd_a_next = `HBMC_LEG_OFF;
    cmd_b_next = `HBMC_LEG_OFF;
    if (!drive_en) begin
      cmd_a_next = `HBMC_LEG_OFF;            // R12
    end else if (step_mode) begin            // R1
      if (overtemp || zero_state) begin      // R6
        cmd_a_next = `HBMC_LEG_OFF;          // R2
      end else if (on_reg) begin
        cmd_a_next = dir ? `HBMC_LEG_HIGH : `HBMC_LEG_LOW;  // R15
        cmd_b_next = dir ? `HBMC_LEG_LOW : `HBMC_LEG_HIGH;  // R15
      end else begin
        cmd_a_next = `HBMC_LEG_LOW;
        cmd_b_next = `HBMC_LEG_LOW;
      end
    end else if (overtemp) begin
      cmd_a_next = `HBMC_LEG_HIGH;           // R7
      cmd_b_next = `HBMC_LEG_HIGH;           // R7
    end else if (dc_pwm) begin
      cmd_a_next = dir ? `HBMC_LEG_HIGH : `HBMC_LEG_LOW;    // R14
      cmd_b_next = dir ? `HBMC_LEG_LOW : `HBMC_LEG_HIGH;    // R14
    end else begin
      cmd_a_next = `HBMC_LEG_LOW;            // R10
      cmd_b_next = `HBMC_LEG_LOW;            // R10
    end
  end

  // Register commands and current level selection
  always @(posedge clk) begin
    if (!rst_n) begin
      cmd_a_reg <= `HBMC_LEG_OFF;
      cmd_b_reg <= `HBMC_LEG_OFF;
      level_reg <= 2'h0;
    end else begin
      cmd_a_reg <= cmd_a_next;
      cmd_b_reg <= cmd_b_next;
      level_reg <= (drive_en && step_mode && !overtemp) ?
                   lvl_decode(lvl_hi, lvl_lo) : 2'h0;        // R17
    end
  end

endmodule // hbmc_phase

/* rtl/hbmc_top.v */
// Purpose: Dual H-bridge motor drive control with regulator clocks
// Assumes: All pin inputs are asynchronous to clk
// Notes:   Index 0,1 are driver one phase A,B; 2,3 driver two A,B
//
// Our own choices: the register offsets and the address-and-strobe port.
`include "hbmc_defines.vh"

////////////////////////////////////////////////////////////////////////

// Behaviour
// R1: Mode pin high step, low DC
// R2: Both level bits high gives fast decay
// R3: Step phases chopped at selectable current levels
// R4: Dead time keeps side switches apart
// R5: Sense ignored during blanking after turn-on
// R6: Step overtemperature forces zero current state
// R7: DC overtemperature drives both outputs high
// R8: Step outputs inhibited while reset asserted
// R9: DC outputs inhibited while reset asserted
// R10: DC drive from PWM pin and bit
// R11: Control bit one enables second regulator
// R12: Cleared enable also disables motor drivers
// R13: Second regulator clock offset half period
// R14: DC direction high: side A sources
// R15: Step direction high: positive terminal sources
// R16: Reset loads control word, enables regulator
// R17: Level bits decode to three levels
module hbmc_top (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire [`HBMC_ADDR_W-1:0] addr,
  input  wire [31:0]             wdata,
  input  wire                    wr,
  input  wire                    rd,
  output reg  [31:0]             rdata_reg,
  input  wire                    driver_one_mode_select,
  input  wire                    driver_two_mode_select,
  input  wire                    dc_pulse_width_input_one,
  input  wire                    dc_pulse_width_input_two,
  input  wire                    over_temp_one,
  input  wire                    over_temp_two,
  input  wire                    reset_pin_n,
  input  wire [3:0]              sense_trip,
  output wire [3:0]              bridge_side_a_hi_gate,
  output wire [3:0]              bridge_side_a_lo_gate,
  output wire [3:0]              bridge_side_b_hi_gate,
  output wire [3:0]              bridge_side_b_lo_gate,
  output wire [7:0]              current_level_sel,
  output reg                     second_regulator_enable_reg,
  output reg                     first_switch_clk_reg,
  output reg                     second_switch_clk_reg
);

  ////////////////////////////////////////////////////////////////////////
  // Constants

  localparam        NSYNC    = 11;                  // Synchronised pins
  localparam integer SW_LAST_I = `HBMC_SW_CYC - 1;  // Counter top, full width
  localparam integer SW_HALF_I = `HBMC_SW_CYC / 2;  // Half period, full width
  localparam integer ON_CYC_I  = `HBMC_ON_CYC;      // On-time, full width
  localparam [8:0]  SW_LAST  = SW_LAST_I[8:0];      // Counter top
  localparam [8:0]  SW_HALF  = SW_HALF_I[8:0];      // Half period
  localparam [8:0]  ON_CYC   = ON_CYC_I[8:0];       // Switch on-time
  localparam [10:0] SYNC_RST = 11'h040;             // Reset pin high, released

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Address match for one register
  function hit;
    input [`HBMC_ADDR_W-1:0] a;
    input [`HBMC_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire [NSYNC-1:0] pin_raw;     // Raw asynchronous pins
  wire [NSYNC-1:0] pin_s;       // Synchronised pins
  reg  [NSYNC-1:0] sync1_reg;   // First stage, read only by second
  reg  [NSYNC-1:0] sync2_reg;   // Second stage

  // Pin order in the bus
  assign pin_raw = {sense_trip, reset_pin_n, over_temp_two,
                    over_temp_one, dc_pulse_width_input_two,
                    dc_pulse_width_input_one, driver_two_mode_select,
                    driver_one_mode_select};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      // Two flops per pin
      always @(posedge clk) begin
        if (!rst_n) begin
          sync1_reg[g] <= SYNC_RST[g];
          sync2_reg[g] <= SYNC_RST[g];
        end else begin
          sync1_reg[g] <= pin_raw[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  assign pin_s = sync2_reg;

  wire [1:0] mode_s  = pin_s[1:0];   // Driver mode selects
  wire [1:0] pwm_s   = pin_s[3:2];   // DC pulse width inputs
  wire [1:0] ovt_s   = pin_s[5:4];   // Overtemperature flags
  wire       rstp_s  = pin_s[6];     // Reset pin level, high released
  wire [3:0] sense_s = pin_s[10:7];  // Current sense trips

  ////////////////////////////////////////////////////////////////////////
  // Control word

  reg [`HBMC_CTRL_W-1:0] ctrl_reg;   // Serial input word image

  wire ctrl_wr = wr && hit(addr, `HBMC_OFS_CTRL);

  // Reset pin low reloads reset values over any write
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= `HBMC_CTRL_RST;
    end else if (!rstp_s) begin
      ctrl_reg <= `HBMC_CTRL_RST;                   // R16
    end else if (ctrl_wr) begin
      ctrl_reg <= wdata[`HBMC_CTRL_W-1:0];
    end
  end

  // Second regulator enable follows bit one
  always @(posedge clk) begin
    if (!rst_n) begin
      second_regulator_enable_reg <= 1'b1;
    end else begin
      second_regulator_enable_reg <= ctrl_reg[`HBMC_BIT_REG_EN];  // R11
    end
  end

  // Drivers run only with reset released and regulator enabled
  wire drive_en = rstp_s && ctrl_reg[`HBMC_BIT_REG_EN];  // R8 R9 R12

  ////////////////////////////////////////////////////////////////////////
  // Switching clocks

  reg [8:0] sw_cnt_reg;    // Position in switching period
  reg       chop_tick_reg; // One pulse per period
  wire [8:0] sw_cnt2;      // Second regulator's position

  // Period counter at 200 kHz
  always @(posedge clk) begin
    if (!rst_n) begin
      sw_cnt_reg    <= 9'h0;
      chop_tick_reg <= 1'b0;
    end else begin
      if (sw_cnt_reg == SW_LAST) begin
        sw_cnt_reg <= 9'h0;
      end else begin
        sw_cnt_reg <= sw_cnt_reg + 9'h1;
      end
      chop_tick_reg <= (sw_cnt_reg == SW_LAST);
    end
  end

  // Second clock runs half a period behind the first
  assign sw_cnt2 = (sw_cnt_reg >= SW_HALF) ? (sw_cnt_reg - SW_HALF) :
                   (sw_cnt_reg + SW_HALF);        // R13

  // Fixed on-time switch clocks
  always @(posedge clk) begin
    if (!rst_n) begin
      first_switch_clk_reg  <= 1'b0;
      second_switch_clk_reg <= 1'b0;
    end else begin
      first_switch_clk_reg  <= (sw_cnt_reg < ON_CYC);
      second_switch_clk_reg <= (sw_cnt2 < ON_CYC) &&
                               ctrl_reg[`HBMC_BIT_REG_EN];   // R13 R11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bridges

  wire [7:0] cmd_a;   // Side A commands, two bits per bridge
  wire [7:0] cmd_b;   // Side B commands

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_br
      // Field positions of this bridge
      localparam BASE = (g < 2) ? `HBMC_DRV1_BASE : `HBMC_DRV2_BASE;
      localparam OFS  = (g % 2 == 0) ? `HBMC_PH_A_OFS : `HBMC_PH_B_OFS;
      localparam DCB  = (g < 2) ? `HBMC_BIT_DC_DIR1 : `HBMC_BIT_DC_DIR2;
      localparam DRV  = g / 2;

      wire step = mode_s[DRV];                          // R1
      wire dirb = step ? ctrl_reg[BASE + OFS + `HBMC_F_DIR] :
                         ctrl_reg[DCB];                 // R14 R15

      // Mode, chopping and fault handling per bridge
      hbmc_phase u_phase (
        .clk        (clk),
        .rst_n      (rst_n),
        .chop_tick  (chop_tick_reg),
        .drive_en   (drive_en),
        .step_mode  (step),
        .dir        (dirb),
        .lvl_lo     (ctrl_reg[BASE + OFS + `HBMC_F_LVL_LO]),
        .lvl_hi     (ctrl_reg[BASE + OFS + `HBMC_F_LVL_HI]),
        .dc_pwm     (pwm_s[DRV]),
        .overtemp   (ovt_s[DRV]),
        .sense_trip (sense_s[g]),
        .cmd_a_reg  (cmd_a[2*g+1:2*g]),
        .cmd_b_reg  (cmd_b[2*g+1:2*g]),
        .level_reg  (current_level_sel[2*g+1:2*g])
      );

      // Side A switches
      hbmc_leg u_leg_a (
        .clk         (clk),
        .rst_n       (rst_n),
        .cmd         (cmd_a[2*g+1:2*g]),
        .hi_gate_reg (bridge_side_a_hi_gate[g]),
        .lo_gate_reg (bridge_side_a_lo_gate[g])
      );

      // Side B switches
      hbmc_leg u_leg_b (
        .clk         (clk),
        .rst_n       (rst_n),
        .cmd         (cmd_b[2*g+1:2*g]),
        .hi_gate_reg (bridge_side_b_hi_gate[g]),
        .lo_gate_reg (bridge_side_b_lo_gate[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Register read

  wire [31:0] stat_word;   // Live status

  // Status: inhibit, overtemperature, modes
  assign stat_word = {26'h0, !rstp_s, !drive_en, ovt_s, mode_s};  // R6 R7

  // Read data stand one cycle only; unmapped reads give zero
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0;
    end else if (rd && hit(addr, `HBMC_OFS_CTRL)) begin
      rdata_reg <= {{(32-`HBMC_CTRL_W){1'b0}}, ctrl_reg};
    end else if (rd && hit(addr, `HBMC_OFS_STAT)) begin
      rdata_reg <= stat_word;
    end else begin
      rdata_reg <= 32'h0;
    end
  end

endmodule // hbmc_top

/* sim/hbmc_sva.sv */
// Purpose: Port checker for the motor drive control
// Assumes: Synchronous active-low reset, one clock
// Notes:   Bound to every hbmc_top instance
module hbmc_sva (
  input logic        clk,
  input logic        rst_n,
  input logic        rd,
  input logic [31:0] rdata_reg,
  input logic        reset_pin_n,
  input logic [3:0]  bridge_side_a_hi_gate,
  input logic [3:0]  bridge_side_a_lo_gate,
  input logic [3:0]  bridge_side_b_hi_gate,
  input logic [3:0]  bridge_side_b_lo_gate,
  input logic        second_regulator_enable_reg,
  input logic        first_switch_clk_reg,
  input logic        second_switch_clk_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  // All sixteen gates in one vector
  wire [15:0] gates = {bridge_side_a_hi_gate, bridge_side_a_lo_gate,
                       bridge_side_b_hi_gate, bridge_side_b_lo_gate};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  a_side_a_apart: assert property (
    !(|(bridge_side_a_hi_gate & bridge_side_a_lo_gate))) else $error("side A both on");
  a_side_b_apart: assert property (
    !(|(bridge_side_b_hi_gate & bridge_side_b_lo_gate))) else $error("side B both on");
  a_dead_gap: assert property (
    $fell(bridge_side_a_hi_gate[0]) |-> !bridge_side_a_lo_gate[0] [*8])
    else $error("no dead time");
  a_reset_state: assert property (
    $rose(rst_n) |-> gates == 16'h0 && second_regulator_enable_reg && rdata_reg == 32'h0)
    else $error("bad reset state");
  a_pin_inhibit: assert property (
    !reset_pin_n [*8] |-> gates == 16'h0) else $error("drive under reset pin");
  a_read_idle: assert property (
    !rd |=> rdata_reg == 32'h0) else $error("read data not idle");
  a_clk_apart: assert property (
    !(first_switch_clk_reg && second_switch_clk_reg)) else $error("clocks in phase");
  a_clk_offset: assert property (
    $rose(first_switch_clk_reg) |->
      ##250 ($rose(second_switch_clk_reg) || !second_regulator_enable_reg))
    else $error("clock offset wrong");
  a_clk_high: assert property (
    $rose(first_switch_clk_reg) |-> ##187 $fell(first_switch_clk_reg))
    else $error("on time wrong");
  a_reg_off: assert property (
    !second_regulator_enable_reg [*2] |-> !second_switch_clk_reg)
    else $error("clock while disabled");
endmodule // hbmc_sva

bind hbmc_top hbmc_sva u_sva (.clk, .rst_n, .rd, .rdata_reg, .reset_pin_n,
  .bridge_side_a_hi_gate, .bridge_side_a_lo_gate, .bridge_side_b_hi_gate,
  .bridge_side_b_lo_gate, .second_regulator_enable_reg, .first_switch_clk_reg,
  .second_switch_clk_reg);

/* sim/hbmc_winding.sv */
// Purpose: Winding load that trips the current comparators
// Assumes: Current grows while a bridge drives across it
// Notes:   Slow raises the trip point; armed low means a light load
module hbmc_winding (
  input  logic       clk,
  input  logic       armed,
  input  logic       slow,
  input  logic [3:0] a_hi,
  input  logic [3:0] a_lo,
  input  logic [3:0] b_hi,
  input  logic [3:0] b_lo,
  output logic [3:0] trip
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [4];  // Drive cycles per winding
  ////////////////////////////////////////////////////////////////
  // Current ramp and comparator per winding
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if ((a_hi[i] && b_lo[i]) || (b_hi[i] && a_lo[i])) begin
        cnt[i] <= cnt[i] + 1;
      end else begin
        cnt[i] <= 0;
      end
      trip[i] <= armed && (cnt[i] >= (slow ? 250 : 20));
    end
  end
endmodule // hbmc_winding

/* sim/hbmc_top_test.sv */
// Purpose: Self-checking bench for the motor drive control
// Assumes: Inputs change by NBA at rising edges, checks at falling
// Notes:   Winding model closes the current loop
module hbmc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        m1 = 1'b1, m2 = 1'b1, p1 = 1'b0, p2 = 1'b0;  // Mode and PWM pins
  logic        t1 = 1'b0, t2 = 1'b0, rpin_n = 1'b1;          // Thermal and reset pins
  logic        armed = 1'b0, slow = 1'b0, ren, c1, c2;
  logic [3:0]  trip, ahi, alo, bhi, blo;
  logic [7:0]  lvl;
  int          miscompares = 0, checks = 0;
  hbmc_top u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_reg(rdata), .driver_one_mode_select(m1),
    .driver_two_mode_select(m2), .dc_pulse_width_input_one(p1),
    .dc_pulse_width_input_two(p2), .over_temp_one(t1), .over_temp_two(t2),
    .reset_pin_n(rpin_n), .sense_trip(trip), .bridge_side_a_hi_gate(ahi),
    .bridge_side_a_lo_gate(alo), .bridge_side_b_hi_gate(bhi),
    .bridge_side_b_lo_gate(blo), .current_level_sel(lvl),
    .second_regulator_enable_reg(ren), .first_switch_clk_reg(c1),
    .second_switch_clk_reg(c2));
  hbmc_winding u_load (.clk(clk), .armed(armed), .slow(slow), .a_hi(ahi),
    .a_lo(alo), .b_hi(bhi), .b_lo(blo), .trip(trip));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_t(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_t(logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // Control word: per bridge {dir, level low, level high}
  function automatic logic [31:0] cw(logic [2:0] b0, b1, b2, b3, logic d1, d2, en);
    return {10'h0, b0, b1, 2'h0, d1, d2, 4'h0, b2, b3, en, 1'b0};
  endfunction
  // Gates of one bridge as {a_hi, a_lo, b_hi, b_lo}
  function automatic logic [3:0] g(int i);
    return {ahi[i], alo[i], bhi[i], blo[i]};
  endfunction
  task automatic wait_g(int i, logic [3:0] e);
    int n = 0;
    while (g(i) !== e && n < 800) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic count_on(output int n);
    n = 0;
    while (ahi[0] === 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] v;
    rd_t(4'h0, v);
    chk("ctrl", v, 32'h1b006e);
    chk("reg en", ren, 1'b1);
    chk("gates", {ahi, alo, bhi, blo}, 16'h0);
    rd_t(4'h4, v);
    chk("status", v, 32'h3);
    rd_t(4'h8, v);
    chk("unmapped", v, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_levels();
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wr_t(4'h0, cw({1'b1, c[0], c[1]}, {1'b1, c[0], c[1]},
        {1'b1, c[0], c[1]}, {1'b1, c[0], c[1]}, 1'b0, 1'b0, 1'b1));
      cyc(5);
      chk("level", lvl, {4{2'h3 - c}});
    end
    cyc(600);
    chk("fast decay", {ahi, alo, bhi, blo}, 16'h0);
    $display("t_levels done");
  endtask
  task automatic t_step();
    int n;
    @(posedge clk);
    armed <= 1'b1;
    wr_t(4'h0, cw(3'h4, 3'h3, 3'h3, 3'h3, 1'b0, 1'b0, 1'b1));
    wait_g(0, 4'b1001);
    chk("fwd", g(0), 4'b1001);
    // First on-phase may start mid-period; measure from the next chop start
    wait_g(0, 4'b0101);
    wait_g(0, 4'b1001);
    count_on(n);
    chk("blank on", n >= 90 && n < 200, 1'b1);
    @(posedge clk);
    slow <= 1'b1;
    cyc(300);
    wait_g(0, 4'b1001);
    count_on(n);
    chk("slow on", n >= 200 && n < 450, 1'b1);
    wr_t(4'h0, cw(3'h0, 3'h3, 3'h3, 3'h3, 1'b0, 1'b0, 1'b1));
    wait_g(0, 4'b0110);
    chk("rev", g(0), 4'b0110);
    $display("t_step done");
  endtask
  task automatic t_ovt();
    @(posedge clk);
    t1 <= 1'b1;
    cyc(80);
    chk("ovt off", {ahi[1:0], alo[1:0], bhi[1:0], blo[1:0]}, 8'h0);
    cyc(500);
    chk("ovt hold", g(0), 4'h0);
    @(posedge clk);
    t1 <= 1'b0;
    wait_g(0, 4'b0110);
    chk("ovt resume", g(0), 4'b0110);
    $display("t_ovt done");
  endtask
  task automatic t_regen();
    logic [31:0] v;
    wr_t(4'h0, cw(3'h0, 3'h3, 3'h3, 3'h3, 1'b0, 1'b0, 1'b0));
    cyc(80);
    chk("reg off", ren, 1'b0);
    chk("clk2 off", c2, 1'b0);
    chk("drv off", g(0), 4'h0);
    rd_t(4'h4, v);
    chk("status", v, 32'h13);
    wr_t(4'h0, cw(3'h0, 3'h3, 3'h3, 3'h3, 1'b0, 1'b0, 1'b1));
    cyc(3);
    chk("reg on", ren, 1'b1);
    wait_g(0, 4'b0110);
    chk("drv back", g(0), 4'b0110);
    $display("t_regen done");
  endtask
  task automatic pin_t();
    logic [31:0] v;
    @(posedge clk);
    rpin_n <= 1'b0;
    cyc(10);
    chk("pin gates", {ahi, alo, bhi, blo}, 16'h0);
    wr_t(4'h0, 32'h0);
    rd_t(4'h0, v);
    chk("pin ctrl", v, 32'h1b006e);
    chk("pin reg", ren, 1'b1);
    @(posedge clk);
    rpin_n <= 1'b1;
    cyc(5);
    $display("pin_t done");
  endtask
  task automatic dc_set(logic d, logic p, logic t, logic [3:0] e);
    @(posedge clk);
    {m1, m2, p1, p2, t1, t2, armed} <= {2'b00, p, p, t, t, 1'b0};
    wr_t(4'h0, cw(3'h3, 3'h3, 3'h3, 3'h3, d, d, 1'b1));
    cyc(80);
    for (int i = 0; i < 4; i++) chk("dc gates", g(i), e);
  endtask
  task automatic t_dc();
    dc_set(1'b1, 1'b1, 1'b0, 4'b1001);
    dc_set(1'b0, 1'b1, 1'b0, 4'b0110);
    dc_set(1'b0, 1'b0, 1'b0, 4'b0101);
    dc_set(1'b0, 1'b1, 1'b1, 4'b1010);
    dc_set(1'b1, 1'b1, 1'b0, 4'b1001);
    $display("t_dc done");
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_levels();
    t_step();
    t_ovt();
    t_regen();
    pin_t();
    t_dc();
    pin_t();
    final_report();
  end
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule // hbmc_top_test
